// File: ibce_pkg.sv
package ibce_pkg;
    localparam int          CLK_HZ        = 125000000;
    localparam int          TIMEOUT_US    = 500;
    localparam int          TIMEOUT_CYC   = (CLK_HZ / 1000000) * TIMEOUT_US;
    localparam int          SCL_HZ        = 100000;
    localparam int          QUARTER_CYC   = CLK_HZ / (SCL_HZ * 4);
    localparam int          BUS_FREE_CYC  = 600;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    localparam logic [3:0]  ACK_BIT_IDX   = 4'h8;
    localparam logic        DIR_READ      = 1'b1;
    localparam logic [1:0]  CMD_ADDRESS   = 2'h0;
    localparam logic [1:0]  CMD_WRITE     = 2'h1;
    localparam logic [1:0]  CMD_READ      = 2'h2;
    localparam logic [1:0]  CMD_STOP      = 2'h3;
    localparam int          FIFO_DEPTH    = 32;
    localparam int          FIFO_WIDTH    = 8;
endpackage : ibce_pkg

// File: ibce_fifo.sv
`timescale 1ns/1ps
module ibce_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,     // System clock
    input  wire logic             rstn,    // Sync reset, active low
    input  wire logic             ce,      // Clock enable
    input  wire logic             in_valid, // Write request
    output logic                  in_ready, // Space available
    input  wire logic [WIDTH-1:0] in_data, // Write data
    output logic                  out_valid, // Data available
    input  wire logic             out_ready, // Read accept
    output logic      [WIDTH-1:0] out_data // Read data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             wr;
    logic             rd;
    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;
    always_ff @(posedge clk)
    begin
        if (ce && wr)
            mem[wp_r] <= in_data;
    end
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else if (ce)
        begin
            if (wr)
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            if (rd)
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            if (wr && !rd)
                cnt_r <= cnt_r + 1'b1;
            else if (rd && !wr)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule : ibce_fifo

// File: ibce_engine.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Wait for a free bus before any address phase.
// - Address command sends START then the target address byte.
// - No acknowledge on address ninth bit ends the attempt with STOP.
// - Retry address until acknowledged, at most the attempt count in total.
// - Received byte acknowledged when ack_disable is 0, not when it is 1.
// - Write command in the addressed direction completes only once the byte is sent or arbitration is lost.
// - Write works as master transmitter and as addressed target.
// - Read returns a bus byte as master receiver and as target.
// - Stop command completes only once STOP is on the bus.
// - Master operation aborts with timeout about 500 us after request.
// - Ninth-bit state recorded active low: 0 acked, 1 not acked.
// - Lost arbitration flagged when another master wins the bus.
module ibce_engine #(
    parameter int TIMEOUT_CYC = ibce_pkg::TIMEOUT_CYC,
    parameter int QUARTER_CYC = ibce_pkg::QUARTER_CYC,
    parameter int BUS_FREE_CYC = ibce_pkg::BUS_FREE_CYC
) (
    input  wire logic       clk,                   // System clock
    input  wire logic       rstn,                  // Sync reset, active low
    input  wire logic       ce,                    // Clock enable
    input  wire logic       cmd_valid,             // Command request
    output logic            cmd_ready,             // Engine idle
    input  wire logic [1:0] cmd_code,              // Command code
    input  wire logic [7:0] target_address,        // Address byte incl. direction
    input  wire logic [7:0] tx_byte,               // Byte to transmit
    input  wire logic       ack_disable,           // 1: do not acknowledge
    input  wire logic [7:0] address_attempt_count, // Max address attempts
    input  wire logic       target_mode,           // Byte commands act as target
    output logic            done_r,                // Command finished pulse
    output logic            ack_status_r,          // Ninth bit, active low
    output logic            timeout_r,             // Timeout flag
    output logic            arbitration_lost_flag, // Lost arbitration
    output logic            rx_valid,              // Received byte available
    input  wire logic       rx_ready,              // Received byte taken
    output logic      [7:0] rx_data,               // Received byte
    input  wire logic       scl_i,                 // SCL pin level
    output logic            scl_o,                 // SCL drive value
    output logic            scl_oe,                // SCL pull low enable
    input  wire logic       sda_i,                 // SDA pin level
    output logic            sda_o,                 // SDA drive value
    output logic            sda_oe                 // SDA pull low enable
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FREE  = 3'b001,
        ST_START = 3'b011,
        ST_BIT   = 3'b010,
        ST_STOP  = 3'b110,
        ST_TGT   = 3'b111,
        ST_DONE  = 3'b101
    } ibce_state_t;

    ibce_state_t state_r;
    logic [1:0]  cmd_r;
    logic [1:0]  ph_r;
    logic [15:0] qcnt_r;
    logic [31:0] tcnt_r;
    logic [15:0] fcnt_r;
    logic [3:0]  bit_r;
    logic [7:0]  sh_r;
    logic [7:0]  tries_r;
    logic        nack_r;
    logic        retry_r;
    logic        dir_r;
    logic [1:0]  scl_s_r;
    logic [1:0]  sda_s_r;
    logic        scl_q;
    logic        sda_q;
    logic        scl_d_r;
    logic        sda_d_r;
    logic        tick;
    logic        busy_bus_r;
    logic        rx_push;
    logic        rx_in_ready;

    function automatic logic drv_bit(input logic [3:0] idx, input logic [7:0] d, input logic na, input logic rd);
        if (idx == ibce_pkg::ACK_BIT_IDX)
            drv_bit = rd ? na : 1'b1;
        else
            drv_bit = rd ? 1'b1 : d[7];
    endfunction : drv_bit

    assign scl_q = scl_s_r[1];
    assign sda_q = sda_s_r[1];
    assign tick  = (qcnt_r == 16'(QUARTER_CYC - 1));
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign cmd_ready = (state_r == ST_IDLE);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else if (ce)
        begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            scl_d_r <= scl_q;
            sda_d_r <= sda_q;
        end
    end

    // Bus busy between any START and STOP seen, also from other masters
    always_ff @(posedge clk)
    begin
        if (!rstn)
            busy_bus_r <= 1'b0;
        else if (ce)
        begin
            if (scl_q && sda_d_r && !sda_q)
                busy_bus_r <= 1'b1;
            else if (scl_q && !sda_d_r && sda_q)
                busy_bus_r <= 1'b0;
        end
    end

    // Idle-high time before the bus counts as free
    always_ff @(posedge clk)
    begin
        if (!rstn)
            fcnt_r <= '0;
        else if (ce)
        begin
            if (busy_bus_r || !scl_q || !sda_q)
                fcnt_r <= '0;
            else if (fcnt_r != 16'(BUS_FREE_CYC))
                fcnt_r <= fcnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            qcnt_r <= '0;
        else if (ce)
            qcnt_r <= (tick || state_r == ST_IDLE) ? '0 : qcnt_r + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            tcnt_r <= '0;
        else if (ce)
            tcnt_r <= (state_r == ST_IDLE) ? '0 : tcnt_r + 1'b1;
    end

    // One push per byte: a stretched ninth clock holds ph_r at 2 over several ticks
    assign rx_push = bit_r == ibce_pkg::ACK_BIT_IDX && cmd_r == ibce_pkg::CMD_READ &&
                     ((state_r == ST_BIT && tick && ph_r == 2'h2 && scl_q) ||
                      (state_r == ST_TGT && !scl_d_r && scl_q));

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r <= ST_IDLE;
            cmd_r <= ibce_pkg::CMD_ADDRESS;
            ph_r <= '0;
            bit_r <= '0;
            sh_r <= '0;
            tries_r <= '0;
            nack_r <= 1'b0;
            retry_r <= 1'b0;
            dir_r <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            done_r <= 1'b0;
            ack_status_r <= 1'b0;
            timeout_r <= 1'b0;
            arbitration_lost_flag <= 1'b0;
        end
        else if (ce)
        begin
            done_r <= 1'b0;
            if (state_r != ST_IDLE && state_r != ST_DONE && tcnt_r >= 32'(TIMEOUT_CYC))
            begin
                timeout_r <= 1'b1;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                state_r <= ST_DONE;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        if (cmd_valid && rx_in_ready)
                        begin
                            cmd_r <= cmd_code;
                            ph_r <= '0;
                            bit_r <= '0;
                            nack_r <= ack_disable;
                            timeout_r <= 1'b0;
                            arbitration_lost_flag <= 1'b0;
                            if (cmd_code == ibce_pkg::CMD_ADDRESS)
                            begin
                                sh_r <= target_address;
                                tries_r <= address_attempt_count;
                                dir_r <= (target_address[0] == ibce_pkg::DIR_READ);
                                state_r <= ST_FREE;
                            end
                            else if (cmd_code == ibce_pkg::CMD_STOP)
                                state_r <= ST_STOP;
                            // In master mode, a byte command against the addressed direction ends without touching the bus
                            else if (!target_mode && dir_r != (cmd_code == ibce_pkg::CMD_READ))
                                state_r <= ST_DONE;
                            else
                            begin
                                sh_r <= tx_byte;
                                // A target must present its first bit before the master's first rise
                                if (target_mode)
                                    sda_oe <= !drv_bit(4'h0, tx_byte, ack_disable,
                                                       cmd_code == ibce_pkg::CMD_READ);
                                state_r <= target_mode ? ST_TGT : ST_BIT;
                            end
                        end
                    end
                    ST_FREE:
                    begin
                        if (tries_r == '0)
                            state_r <= ST_DONE;
                        else if (fcnt_r == 16'(BUS_FREE_CYC))
                        begin
                            state_r <= ST_START;
                            ph_r <= '0;
                        end
                    end
                    ST_START:
                    begin
                        if (tick)
                        begin
                            ph_r <= ph_r + 1'b1;
                            if (ph_r == 2'h0)
                                sda_oe <= 1'b1;
                            else if (ph_r == 2'h1)
                            begin
                                scl_oe <= 1'b1;
                                state_r <= ST_BIT;
                                ph_r <= '0;
                                bit_r <= '0;
                                tries_r <= tries_r - 1'b1;
                                cmd_r <= ibce_pkg::CMD_ADDRESS;
                            end
                        end
                    end
                    ST_BIT, ST_TGT:
                    begin
                        if (state_r == ST_TGT)
                        begin
                            // Target side: follow the other master's SCL
                            if (scl_d_r && !scl_q)
                            begin
                                // Done only once the ninth clock has gone low again
                                if (bit_r == ibce_pkg::ACK_BIT_IDX + 4'h1)
                                    state_r <= ST_DONE;
                                else
                                    sda_oe <= !drv_bit(bit_r, sh_r, nack_r, cmd_r == ibce_pkg::CMD_READ);
                            end
                            else if (!scl_d_r && scl_q)
                            begin
                                if (bit_r == ibce_pkg::ACK_BIT_IDX)
                                    ack_status_r <= sda_q;
                                else
                                    sh_r <= {sh_r[6:0], sda_q};
                                bit_r <= bit_r + 1'b1;
                            end
                        end
                        else if (tick)
                        begin
                            ph_r <= ph_r + 1'b1;
                            case (ph_r)
                                2'h0:
                                    sda_oe <= !drv_bit(bit_r, sh_r, nack_r, cmd_r == ibce_pkg::CMD_READ &&
                                                       bit_r != ibce_pkg::ACK_BIT_IDX ? 1'b1 :
                                                       cmd_r == ibce_pkg::CMD_READ);
                                2'h1:
                                    scl_oe <= 1'b0;
                                2'h2:
                                begin
                                    if (!scl_q)
                                        ph_r <= ph_r; // Clock stretching by a target
                                    else if (bit_r == ibce_pkg::ACK_BIT_IDX)
                                        ack_status_r <= sda_q;
                                    else
                                    begin
                                        if (!sda_oe && !sda_q && cmd_r != ibce_pkg::CMD_READ)
                                        begin
                                            arbitration_lost_flag <= 1'b1;
                                            state_r <= ST_DONE;
                                        end
                                        sh_r <= {sh_r[6:0], sda_q};
                                    end
                                end
                                default:
                                begin
                                    scl_oe <= 1'b1;
                                    bit_r <= bit_r + 1'b1;
                                    if (bit_r == ibce_pkg::ACK_BIT_IDX)
                                    begin
                                        // SDA lets go in ST_DONE, once SCL is already low
                                        if (cmd_r == ibce_pkg::CMD_ADDRESS && ack_status_r)
                                        begin
                                            retry_r <= 1'b1;
                                            state_r <= ST_STOP;
                                        end
                                        else
                                            state_r <= ST_DONE;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_STOP:
                    begin
                        if (tick)
                        begin
                            ph_r <= ph_r + 1'b1;
                            if (ph_r == 2'h0)
                            begin
                                scl_oe <= 1'b1;
                                sda_oe <= 1'b1;
                            end
                            else if (ph_r == 2'h1)
                                scl_oe <= 1'b0;
                            else if (ph_r == 2'h2)
                                sda_oe <= 1'b0;
                            else if (retry_r)
                            begin
                                retry_r <= 1'b0;
                                state_r <= ST_FREE;
                            end
                            else
                                state_r <= ST_DONE;
                        end
                    end
                    ST_DONE:
                    begin
                        done_r <= 1'b1;
                        sda_oe <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                    default:
                        state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Received bytes wait here so the host may drain them late
    ibce_fifo #(
        .WIDTH (ibce_pkg::FIFO_WIDTH),
        .DEPTH (ibce_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (sh_r),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    a_ack_records: assert property (@(posedge clk) disable iff (!rstn)
        (ce && state_r == ST_BIT && tick && ph_r == 2'h2 && scl_q && bit_r == ibce_pkg::ACK_BIT_IDX)
        |=> ack_status_r == $past(sda_q)) else $error("ack status wrong");
    a_done_idle: assert property (@(posedge clk) disable iff (!rstn)
        done_r |-> state_r == ST_IDLE) else $error("done not idle");
    a_start_cond: assert property (@(posedge clk) disable iff (!rstn)
        ($past(state_r) == ST_START && state_r == ST_BIT) |-> sda_oe && scl_oe)
        else $error("start not driven");
    a_free_gate: assert property (@(posedge clk) disable iff (!rstn)
        ($past(state_r) == ST_FREE && state_r == ST_START) |-> $past(fcnt_r) == 16'(BUS_FREE_CYC))
        else $error("start while bus busy");
    a_timeout_set: assert property (@(posedge clk) disable iff (!rstn)
        $rose(timeout_r) |-> $past(tcnt_r) >= 32'(TIMEOUT_CYC)) else $error("early timeout");
    a_nack_stop: assert property (@(posedge clk) disable iff (!rstn)
        ($past(state_r) == ST_BIT && state_r == ST_STOP) |-> retry_r && ack_status_r)
        else $error("stop without nack");
    a_tries_cap: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == ST_FREE && tries_r == '0 && ce && !timeout_r && tcnt_r < 32'(TIMEOUT_CYC))
        |=> state_r == ST_DONE) else $error("extra attempt");
    a_stop_release: assert property (@(posedge clk) disable iff (!rstn)
        ($past(state_r) == ST_STOP && state_r == ST_DONE && !timeout_r) |-> !sda_oe && !scl_oe)
        else $error("stop not sent");
endmodule : ibce_engine

// File: ibce_target_model.sv
`timescale 1ns/1ps
module ibce_target_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input  wire logic       scl,        // Bus clock wire
    input  wire logic       sda,        // Bus data wire
    input  wire logic [7:0] nack_first, // Attempts refused before ack
    input  wire logic [7:0] rd_byte,    // Byte returned on reads
    output logic            sda_oe      // Pull data low
);
    int         starts  = 0;
    int         stops   = 0;
    logic [3:0] bitn    = 4'hf;
    logic [7:0] sh      = 8'h00;
    logic [7:0] last_wr = 8'h00;
    logic [7:0] tries   = 8'h00;
    logic       active  = 1'b0;
    logic       first   = 1'b0;
    logic       rd      = 1'b0;
    logic       ack_it  = 1'b0;
    logic       m_ack   = 1'b0;
    initial sda_oe = 1'b0;
    always @(negedge sda)
        if (scl === 1'b1)
        begin
            starts = starts + 1;
            active = 1'b1;
            first  = 1'b1;
            bitn   = 4'hf;
            m_ack  = 1'b0;
        end
    always @(posedge sda)
        if (scl === 1'b1)
        begin
            stops  = stops + 1;
            active = 1'b0;
        end
    always @(posedge scl)
        if (active && bitn < 4'h8)
            sh = {sh[6:0], sda};
        else if (active && rd && !first)
            m_ack = sda;
    always @(negedge scl)
        if (active)
        begin
            if (bitn == 4'h8)
            begin
                bitn  = 4'h0;
                first = 1'b0;
            end
            else
                bitn = bitn + 4'h1;
            if (bitn == 4'h8 && first)
            begin
                rd     = sh[0];
                ack_it = (sh[7:1] == ADDR) && (tries >= nack_first);
                tries  = ack_it ? 8'h00 : tries + 8'h01;
            end
            else if (bitn == 4'h8 && !rd)
                last_wr = sh;
            // A refused master gets the line released so it can stop cleanly
            if (bitn == 4'h8)
                sda_oe = ack_it && (first || !rd);
            else
                sda_oe = ack_it && rd && !first && !m_ack && !rd_byte[4'h7 - bitn];
        end
endmodule : ibce_target_model

// File: tb_ibce_engine.sv
`timescale 1ns/1ps
module tb_ibce_engine;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       cmd_valid = 1'b0;
    logic [1:0] cmd_code = 2'h0;
    logic [7:0] target_address = 8'h00;
    logic [7:0] tx_byte = 8'h00;
    logic       ack_disable = 1'b0;
    logic [7:0] attempts = 8'h00;
    logic       rx_ready = 1'b0;
    logic [7:0] nack_first = 8'h00;
    logic       ce = 1'b1;
    logic       cmd_ready, done_r, ack_status_r, timeout_r, lost, rx_valid;
    logic [7:0] rx_data;
    logic       scl_o, scl_oe, sda_o, sda_oe, t_oe;
    wire        scl_w = !scl_oe;
    wire        sda_w = !(sda_oe || t_oe);
    int         num_errors = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         s0, p0;
    always #4 clk = ~clk;
    ibce_engine #(.TIMEOUT_CYC(4000), .QUARTER_CYC(4), .BUS_FREE_CYC(8)) uut (
        .clk(clk), .rstn(rstn), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_code(cmd_code), .target_address(target_address), .tx_byte(tx_byte),
        .ack_disable(ack_disable), .address_attempt_count(attempts), .target_mode(1'b0),
        .done_r(done_r), .ack_status_r(ack_status_r), .timeout_r(timeout_r),
        .arbitration_lost_flag(lost), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
    ibce_target_model tgt (.scl(scl_w), .sda(sda_w), .nack_first(nack_first), .rd_byte(8'hc3), .sda_oe(t_oe));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            num_errors = num_errors + 1;
        end
    endtask : chk
    task automatic run_cmd(input logic [1:0] code, input logic [7:0] adr, input logic [7:0] txb,
                           input logic ackd, input logic [7:0] cnt);
        int n;
        while (cmd_ready !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        cmd_code       <= code;
        target_address <= adr;
        tx_byte        <= txb;
        ack_disable    <= ackd;
        attempts       <= cnt;
        cmd_valid      <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        while (done_r !== 1'b1 && n < 6000)
        begin
            @(negedge clk);
            n = n + 1;
        end
        chk("done before timeout", 8'h01, {7'h00, n < 6000});
    endtask : run_cmd
    task automatic t_addr_retry;
        nack_first = 8'h02;
        s0 = tgt.starts;
        p0 = tgt.stops;
        run_cmd(ibce_pkg::CMD_ADDRESS, 8'ha0, 8'h00, 1'b0, 8'h05);
        chk("attempts made", 8'h03, 8'(tgt.starts - s0));
        chk("stops after refusals", 8'h02, 8'(tgt.stops - p0));
        chk("address ack", 8'h00, {7'h00, ack_status_r});
        chk("timeout flag", 8'h00, {7'h00, timeout_r});
        $display("test addr_retry done");
    endtask : t_addr_retry
    task automatic t_write_stop;
        p0 = tgt.stops;
        run_cmd(ibce_pkg::CMD_WRITE, 8'h00, 8'h5a, 1'b0, 8'h00);
        chk("written byte", 8'h5a, tgt.last_wr);
        chk("write ack", 8'h00, {7'h00, ack_status_r});
        chk("arbitration lost", 8'h00, {7'h00, lost});
        chk("pin drive levels", 8'h00, {6'h00, scl_o, sda_o});
        chk("no stop yet", 8'h00, 8'(tgt.stops - p0));
        // Clock enable low in mid stop must hold the bus where it is
        fork
            run_cmd(ibce_pkg::CMD_STOP, 8'h00, 8'h00, 1'b0, 8'h00);
            begin
                repeat (6) @(posedge clk);
                ce <= 1'b0;
                repeat (30) @(posedge clk);
                chk("stop frozen by ce", 8'h00, 8'(tgt.stops - p0));
                ce <= 1'b1;
            end
        join
        chk("stop sent", 8'h01, 8'(tgt.stops - p0));
        chk("bus idle", 8'h03, {6'h00, scl_w, sda_w});
        $display("test write_stop done");
    endtask : t_write_stop
    task automatic t_read;
        nack_first = 8'h00;
        run_cmd(ibce_pkg::CMD_ADDRESS, 8'ha1, 8'h00, 1'b0, 8'h01);
        for (int i = 0; i < 2; i++)
        begin
            run_cmd(ibce_pkg::CMD_READ, 8'h00, 8'h00, i[0], 8'h00);
            chk("master ack bit", {7'h00, i[0]}, {7'h00, tgt.m_ack});
            chk("ack status", {7'h00, i[0]}, {7'h00, ack_status_r});
            chk("rx valid", 8'h01, {7'h00, rx_valid});
            chk("rx byte", 8'hc3, rx_data);
            @(posedge clk);
            rx_ready <= 1'b1;
            @(posedge clk);
            rx_ready <= 1'b0;
        end
        run_cmd(ibce_pkg::CMD_STOP, 8'h00, 8'h00, 1'b0, 8'h00);
        @(negedge clk);
        chk("fifo drained", 8'h00, {7'h00, rx_valid});
        $display("test read done");
    endtask : t_read
    task automatic t_limit;
        nack_first = 8'hff;
        s0 = tgt.starts;
        p0 = tgt.stops;
        run_cmd(ibce_pkg::CMD_ADDRESS, 8'ha0, 8'h00, 1'b0, 8'h02);
        chk("attempt ceiling", 8'h02, 8'(tgt.starts - s0));
        chk("stop each refusal", 8'h02, 8'(tgt.stops - p0));
        chk("nack status", 8'h01, {7'h00, ack_status_r});
        // Endless refusals: only the timer can end this one
        run_cmd(ibce_pkg::CMD_ADDRESS, 8'ha0, 8'h00, 1'b0, 8'hff);
        chk("timeout flag set", 8'h01, {7'h00, timeout_r});
        $display("test limit done");
    endtask : t_limit
    // Ceiling leaves ample room over the few thousand cycles the tests need
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            num_errors = num_errors + 1;
            print_verdict();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_addr_retry();
        t_write_stop();
        t_read();
        t_limit();
        print_verdict();
    end
endmodule : tb_ibce_engine
